//--- rtl/tos_pkg.sv
package tos_pkg;

    // channel and image geometry
    localparam int unsigned NUM_CH       = 4;
    localparam int unsigned SLOTS_SHORT  = 5;
    localparam int unsigned SLOTS_LONG   = 15;
    localparam int unsigned QUEUE_DEPTH  = 32;
    localparam int unsigned SLOT_W       = 4;

    // fixed parameter values
    localparam logic [7:0]  IN_LEN        = 8'h04;
    localparam logic [7:0]  OUT_LEN_SHORT = 8'h14;
    localparam logic [7:0]  OUT_LEN_LONG  = 8'h3C;

    // parameter addressing
    localparam logic [7:0]  RECORD_SET_LEN = 8'h02;
    localparam logic [15:0] INDEX_IN_LEN   = 16'h3100;
    localparam logic [15:0] INDEX_OUT_LEN  = 16'h3101;
    localparam logic [7:0]  SUB_IN_LEN     = 8'h01;
    localparam logic [7:0]  SUB_OUT_LEN    = 8'h02;

    // sequence number, status byte and pattern fields
    localparam int unsigned SEQ_LAST_BIT   = 6;
    localparam int unsigned SEQ_NUM_W      = 6;
    localparam logic [1:0]  SEQ_NEXT_FLAGS = 2'h3;
    localparam int unsigned STS_LAST_BIT   = 7;
    localparam int unsigned STS_RUN_BIT    = 1;
    localparam int unsigned STS_OVF_BIT    = 0;
    localparam int unsigned PAT_CH0_BIT    = 7;

    typedef struct packed {
        logic [7:0]  pattern;
        logic [7:0]  seq;
        logic [15:0] stamp;
    } entry_t;

    typedef struct packed {
        logic              valid;
        logic [SLOT_W-1:0] slot;
        entry_t            entry;
    } image_wr_t;

    typedef struct packed {
        logic        valid;
        logic        by_index;
        logic [7:0]  record_set;
        logic [15:0] index;
        logic [7:0]  subindex;
    } param_req_t;

    typedef struct packed {
        logic [7:0] last_seq;
        logic [7:0] next_seq;
        logic [7:0] queue_status;
        logic [7:0] pending;
    } status_t;

endpackage : tos_pkg

//--- rtl/entry_queue.sv
`timescale 1ns/100ps
module entry_queue #(
    parameter int unsigned DEPTH = 32,
    parameter int unsigned WIDTH = 32,
    parameter int unsigned CNT_W = $clog2(DEPTH + 1),
    parameter int unsigned PTR_W = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_sys_rst,
    // fill side
    input  wire logic             i_push_valid,
    output logic                  o_push_ready,
    input  wire logic [WIDTH-1:0] i_push_data,
    // drain side
    input  wire logic             i_pop,
    output logic                  o_head_valid,
    output logic [WIDTH-1:0]      o_head,
    output logic [CNT_W-1:0]      o_count
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [CNT_W-1:0]            count;
    } queue_state_t;

    queue_state_t state_q;
    queue_state_t state_d;
    logic         do_push;
    logic         do_pop;

    assign o_push_ready = (state_q.count != CNT_W'(DEPTH));
    assign o_head_valid = (state_q.count != '0);
    assign o_head       = state_q.mem[state_q.rd_ptr];
    assign o_count      = state_q.count;

    always_comb begin
        state_d = state_q;
        do_push = i_push_valid && o_push_ready;
        do_pop  = i_pop && o_head_valid;
        if (do_push) begin
            state_d.mem[state_q.wr_ptr] = i_push_data;
            state_d.wr_ptr = (state_q.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(state_q.wr_ptr + 1'b1);
        end
        if (do_pop) begin
            // slot is cleared so a stale entry never shows as head
            state_d.mem[state_q.rd_ptr] = '0;
            state_d.rd_ptr = (state_q.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(state_q.rd_ptr + 1'b1);
        end
        if (do_push && !do_pop) begin
            state_d.count = CNT_W'(state_q.count + 1'b1);
        end else if (do_pop && !do_push) begin
            state_d.count = CNT_W'(state_q.count - 1'b1);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : entry_queue

//--- rtl/timed_output_scheduler.sv
`timescale 1ns/100ps
module timed_output_scheduler #(
    parameter int unsigned SLOTS_MAX = tos_pkg::SLOTS_LONG,
    parameter int unsigned DEPTH     = tos_pkg::QUEUE_DEPTH
) (
    // clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_sys_rst,
    // configuration and system state
    input  wire logic                 i_long_variant,
    input  wire logic                 i_run_stopped,
    // shared microsecond ticker
    input  wire logic [15:0]          i_us_ticker,
    // output process image writes
    input  tos_pkg::image_wr_t        i_image_wr,
    // parameter record reads
    input  tos_pkg::param_req_t       i_param_req,
    output logic                      o_param_valid,
    output logic [7:0]                o_param_data,
    output logic                      o_param_error,
    // input process image and outputs
    output tos_pkg::status_t          o_input_image,
    output logic [tos_pkg::NUM_CH-1:0] o_channels
);

    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam int unsigned ENT_W = $bits(tos_pkg::entry_t);
    localparam int unsigned SLOT_W_L = tos_pkg::SLOT_W;

    typedef struct packed {
        logic [SLOTS_MAX-1:0][7:0]     slot_seq;
        logic                          cfg_taken;
        logic                          long_variant;
        logic                          ran;
        logic                          overflow;
        logic [7:0]                    exec_seq;
        logic [7:0]                    last_seq;
        logic                          last_marked;
        tos_pkg::status_t              status;
        logic [tos_pkg::NUM_CH-1:0]    channels;
        logic                          param_valid;
        logic [7:0]                    param_data;
        logic                          param_error;
    } sched_state_t;

    sched_state_t         state_q;
    sched_state_t         state_d;
    tos_pkg::entry_t      wr_entry;
    tos_pkg::entry_t      head;
    logic [ENT_W-1:0]     head_raw;
    logic                 head_valid;
    logic                 push_valid;
    logic                 push_ready;
    logic                 accept;
    logic                 pop;
    logic [CNT_W-1:0]     count;
    logic [SLOT_W_L-1:0]  slot;
    logic [SLOT_W_L-1:0]  slots_active;
    logic [7:0]           out_len;
    logic                 is_last_slot;
    logic [tos_pkg::NUM_CH-1:0] head_chan;

    assign wr_entry = i_image_wr.entry;
    assign head     = tos_pkg::entry_t'(head_raw);
    assign slot     = i_image_wr.slot;

    // variant decides image size, and so which slots are live
    assign slots_active = state_q.long_variant ? SLOT_W_L'(tos_pkg::SLOTS_LONG)
                                               : SLOT_W_L'(tos_pkg::SLOTS_SHORT);
    assign out_len = state_q.long_variant ? tos_pkg::OUT_LEN_LONG : tos_pkg::OUT_LEN_SHORT;
    assign is_last_slot = (slot == SLOT_W_L'(slots_active - 1'b1));

    // a slot only queues when its sequence number changes
    // slots beyond the configured image are ignored, never queued
    assign push_valid = i_image_wr.valid && state_q.cfg_taken && (slot < slots_active)
                        && (wr_entry.seq != 8'h00)
                        && (wr_entry.seq != state_q.slot_seq[slot]);
    assign accept = push_valid && push_ready;

    // exact match on the wrapping ticker: a smaller stamp means the next period
    assign pop = head_valid && (head.stamp == i_us_ticker);

    // channel i follows pattern bit 7-i
    for (genvar g = 0; g < tos_pkg::NUM_CH; g++) begin : g_chan
        assign head_chan[g] = head.pattern[tos_pkg::PAT_CH0_BIT - g];
    end

    // default depth leaves one spare entry beyond the 31 promised
    entry_queue #(
        .DEPTH (DEPTH),
        .WIDTH (ENT_W)
    ) u_queue (
        .i_core_clk   (i_core_clk),
        .i_sys_rst    (i_sys_rst),
        .i_push_valid (push_valid),
        .o_push_ready (push_ready),
        .i_push_data  (wr_entry),
        .i_pop        (pop),
        .o_head_valid (head_valid),
        .o_head       (head_raw),
        .o_count      (count)
    );

    always_comb begin
        state_d = state_q;
        state_d.param_valid = 1'b0;
        state_d.param_error = 1'b0;

        // variant strap is caught once, after reset release
        if (!state_q.cfg_taken) begin
            state_d.cfg_taken    = 1'b1;
            state_d.long_variant = i_long_variant;
        end

        if (accept) begin
            state_d.slot_seq[slot] = wr_entry.seq;
            // an entry in the final slot is marked last in last_seq; last_marked keeps the written bit 6
            state_d.last_seq = is_last_slot ? (wr_entry.seq | 8'(1 << tos_pkg::SEQ_LAST_BIT))
                                            : wr_entry.seq;
            state_d.last_marked = wr_entry.seq[tos_pkg::SEQ_LAST_BIT];
        end else if (push_valid) begin
            // queue full: entry dropped, slot kept so a rewrite retries
            state_d.overflow = 1'b1;
        end

        if (pop) begin
            state_d.channels = head_chan;
            state_d.ran      = 1'b1;
            state_d.exec_seq = head.seq;
        end

        // input image, one cycle behind the queue
        state_d.status.last_seq = state_q.last_seq;
        state_d.status.next_seq = {tos_pkg::SEQ_NEXT_FLAGS,
                                   head_valid ? head.seq[tos_pkg::SEQ_NUM_W-1:0]
                                              : tos_pkg::SEQ_NUM_W'(state_q.exec_seq + 1'b1)};
        state_d.status.queue_status = '0;
        state_d.status.queue_status[tos_pkg::STS_LAST_BIT] = state_q.last_marked;
        state_d.status.queue_status[tos_pkg::STS_RUN_BIT]  = state_q.ran;
        state_d.status.queue_status[tos_pkg::STS_OVF_BIT]  = state_q.overflow;
        state_d.status.pending = 8'(count);

        // read-only parameter record; nothing here can store a new value
        if (i_param_req.valid) begin
            state_d.param_valid = 1'b1;
            state_d.param_data  = 8'h00;
            state_d.param_error = 1'b1;
            if (i_run_stopped) begin
                if (i_param_req.by_index) begin
                    if (i_param_req.index == tos_pkg::INDEX_IN_LEN) begin
                        state_d.param_data  = tos_pkg::IN_LEN;
                        state_d.param_error = 1'b0;
                    end else if (i_param_req.index == tos_pkg::INDEX_OUT_LEN) begin
                        state_d.param_data  = out_len;
                        state_d.param_error = 1'b0;
                    end
                end else if (i_param_req.record_set == tos_pkg::RECORD_SET_LEN) begin
                    if (i_param_req.subindex == tos_pkg::SUB_IN_LEN) begin
                        state_d.param_data  = tos_pkg::IN_LEN;
                        state_d.param_error = 1'b0;
                    end else if (i_param_req.subindex == tos_pkg::SUB_OUT_LEN) begin
                        state_d.param_data  = out_len;
                        state_d.param_error = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_param_valid = state_q.param_valid;
    assign o_param_data  = state_q.param_data;
    assign o_param_error = state_q.param_error;
    assign o_input_image = state_q.status;
    assign o_channels    = state_q.channels;

    // checks

    a_in_len_fixed: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_param_req.valid && i_run_stopped && i_param_req.by_index
         && i_param_req.index == tos_pkg::INDEX_IN_LEN)
        |=> (o_param_valid && !o_param_error && o_param_data == 8'h04))
        else $error("input length not four bytes");

    a_out_len_variant: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_param_req.valid && i_run_stopped && !i_param_req.by_index
         && i_param_req.record_set == 8'h02 && i_param_req.subindex == 8'h02)
        |=> (o_param_data == (state_q.long_variant ? 8'h3C : 8'h14)))
        else $error("output length does not match variant");

    a_params_const: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_param_valid && !o_param_error) |-> (o_param_data inside {8'h04, 8'h14, 8'h3C}))
        else $error("parameter value not a fixed constant");

    a_ch0_pattern: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        pop |=> (o_channels[0] == $past(head.pattern[7]) && o_channels[1] == $past(head.pattern[6])))
        else $error("head pattern not applied");

    a_ch3_order: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        pop |=> (o_channels[3] == $past(head.pattern[4]) && o_channels[2] == $past(head.pattern[5])))
        else $error("pattern bit order wrong");

    a_hold_no_exec: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!pop && state_q.cfg_taken) |=> $stable(o_channels))
        else $error("outputs changed with no entry due");

    a_queue_copy: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (accept && !pop) |=> (count == $past(count) + 1'b1))
        else $error("accepted entry not queued");

    a_count_drops: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (pop && !accept) |=> (count == $past(count) - 1'b1) ##1 (o_input_image.pending == 8'($past(count))))
        else $error("pending count not reduced by one");

    a_dup_ignored: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_image_wr.valid && wr_entry.seq == state_q.slot_seq[slot] && !pop) |=> $stable(count))
        else $error("duplicate sequence number queued");

    a_last_seq: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        accept |-> ##2 (o_input_image.last_seq[5:0] == $past(wr_entry.seq[5:0], 2)))
        else $error("last sequence number not reported");

    // parameter record answers

    a_refuse_running: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_param_req.valid && !i_run_stopped)
        |=> (o_param_valid && o_param_error && o_param_data == 8'h00))
        else $error("parameter answered outside stopped state");

    a_index_out_len: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_param_req.valid && i_run_stopped && i_param_req.by_index
         && i_param_req.index == 16'h3101)
        |=> (o_param_valid && !o_param_error && o_param_data == (state_q.long_variant ? 8'h3C : 8'h14)))
        else $error("output length by index wrong");

    a_sub_in_len: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_param_req.valid && i_run_stopped && !i_param_req.by_index
         && i_param_req.record_set == 8'h02 && i_param_req.subindex == 8'h01)
        |=> (o_param_valid && !o_param_error && o_param_data == 8'h04))
        else $error("input length by record set wrong");

    a_unknown_addr: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_param_req.valid && i_run_stopped && i_param_req.by_index
         && !(i_param_req.index inside {16'h3100, 16'h3101}))
        |=> (o_param_valid && o_param_error))
        else $error("unknown index answered without error");

    a_answer_pulse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !i_param_req.valid |=> !o_param_valid)
        else $error("parameter answer without request");

    // queue and status

    a_pending_tracks: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        1'b1 |=> (o_input_image.pending == 8'($past(count))))
        else $error("pending count does not follow queue");

    a_next_flags: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        state_q.cfg_taken |=> (o_input_image.next_seq[7:6] == 2'b11))
        else $error("next sequence flags not set");

    a_last_marked: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        accept |-> ##2 (o_input_image.queue_status[7] == $past(wr_entry.seq[6], 2)))
        else $error("last entry mark not reported");

    a_overflow_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_input_image.queue_status[0] |=> o_input_image.queue_status[0])
        else $error("overflow flag cleared without reset");

    a_full_drop: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (push_valid && !push_ready) |-> ##2 o_input_image.queue_status[0])
        else $error("dropped entry not flagged");

    a_short_range: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_image_wr.valid && state_q.cfg_taken && !state_q.long_variant
         && i_image_wr.slot >= 4'h5 && !pop) |=> $stable(count))
        else $error("slot outside short image queued");

    a_head_compare: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (head_valid && head.stamp != i_us_ticker) |=> $stable(o_channels))
        else $error("entry applied before its time");

endmodule : timed_output_scheduler

//--- dv/us_ticker_model.sv
`timescale 1ns/100ps
module us_ticker_model (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    // preset from the bench
    input  wire logic        i_load,
    input  wire logic [15:0] i_load_value,
    // shared ticker
    output logic [15:0]      o_us_ticker
);
    // one count per clock stands in for one microsecond, keeps runs short
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_us_ticker <= 16'h0000;
        end else if (i_load) begin
            o_us_ticker <= i_load_value;
        end else begin
            o_us_ticker <= o_us_ticker + 16'h0001;
        end
    end
endmodule : us_ticker_model

//--- dv/timed_output_scheduler_test.sv
`timescale 1ns/100ps
module timed_output_scheduler_test;
    logic                clk;
    logic                rst;
    logic                long_variant;
    logic                run_stopped;
    logic                tick_load;
    logic [15:0]         tick_value;
    logic [15:0]         us_ticker;
    tos_pkg::image_wr_t  image_wr;
    tos_pkg::param_req_t param_req;
    logic                param_valid;
    logic [7:0]          param_data;
    logic                param_error;
    tos_pkg::status_t    input_image;
    logic [3:0]          channels;
    int                  mismatches;
    int                  total_checks;
    logic [15:0]         lfsr;
    logic [7:0]          prev_pending;
    logic [8:0]          exp_param [$];
    logic [3:0]          exp_chan [$];

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    us_ticker_model TICK (.i_core_clk(clk), .i_sys_rst(rst), .i_load(tick_load), .i_load_value(tick_value),
                          .o_us_ticker(us_ticker));

    timed_output_scheduler DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_long_variant(long_variant),
                                .i_run_stopped(run_stopped), .i_us_ticker(us_ticker), .i_image_wr(image_wr),
                                .i_param_req(param_req), .o_param_valid(param_valid), .o_param_data(param_data),
                                .o_param_error(param_error), .o_input_image(input_image), .o_channels(channels));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [3:0] chan_of(input logic [7:0] pat);
        logic [3:0] c;
        for (int i = 0; i < 4; i++) c[i] = pat[7 - i];
        return c;
    endfunction : chan_of

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic do_reset(input logic variant);
        rst = 1'b1;
        long_variant = variant;
        step(16);
        rst = 1'b0;
        // first edge after release only captures the variant
        step(2);
    endtask : do_reset

    task automatic load_ticker(input logic [15:0] value);
        tick_load = 1'b1;
        tick_value = value;
        step(1);
        tick_load = 1'b0;
    endtask : load_ticker

    // leaves valid high; caller lowers it after the batch
    task automatic write_slot(input logic [3:0] slot, input logic [7:0] seq, input logic [7:0] pat,
                              input logic [15:0] stamp, input logic expect_run);
        image_wr = '{valid: 1'b1, slot: slot, entry: '{pattern: pat, seq: seq, stamp: stamp}};
        if (expect_run) exp_chan.push_back(chan_of(pat));
        step(1);
    endtask : write_slot

    task automatic read_param(input logic by_index, input logic [15:0] idx, input logic [7:0] sub,
                              input logic [8:0] exp);
        param_req = '{valid: 1'b1, by_index: by_index, record_set: 8'h02, index: idx, subindex: sub};
        exp_param.push_back(exp);
        step(1);
        param_req.valid = 1'b0;
        step(1);
    endtask : read_param

    task automatic wait_pending(input logic [7:0] target);
        int n;
        n = 0;
        while (input_image.pending !== target && n < 300) begin
            step(1);
            n++;
        end
        step(1);
        check("pending", input_image.pending, target);
    endtask : wait_pending

    always @(posedge clk) begin
        #2;
        if (param_valid === 1'b1) begin
            if (exp_param.size() == 0) check("param_extra", 32'h1, 32'h0);
            else check("param_answer", {param_error, param_data}, exp_param.pop_front());
        end
        if (input_image.pending < prev_pending && exp_chan.size() > 0) begin
            check("channels", channels, exp_chan.pop_front());
        end
        prev_pending = input_image.pending;
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        long_variant = 1'b0;
        run_stopped = 1'b1;
        tick_load = 1'b0;
        tick_value = 16'h0000;
        image_wr = '0;
        param_req = '0;
        mismatches = 0;
        total_checks = 0;
        lfsr = 16'h40A3;
        prev_pending = 8'h00;
        do_reset(1'b0);
        read_param(1'b1, 16'h3100, 8'h00, 9'h004);
        read_param(1'b1, 16'h3101, 8'h00, 9'h014);
        read_param(1'b0, 16'h0000, 8'h01, 9'h004);
        read_param(1'b0, 16'h0000, 8'h02, 9'h014);
        read_param(1'b1, 16'h3102, 8'h00, 9'h100);
        read_param(1'b0, 16'h0000, 8'h03, 9'h100);
        run_stopped = 1'b0;
        read_param(1'b1, 16'h3100, 8'h00, 9'h100);
        run_stopped = 1'b1;
        $display("test parameters done");
        load_ticker(16'h0000);
        for (int k = 0; k < 5; k++) begin
            lfsr = lfsr_next(lfsr);
            write_slot(k[3:0], 8'(k + 1), lfsr[7:0], 16'(40 + 10 * k), 1'b1);
        end
        // unchanged sequence, empty sequence and out-of-range slot add nothing
        write_slot(4'h0, 8'h01, 8'hFF, 16'h0010, 1'b0);
        write_slot(4'h1, 8'h00, 8'hFF, 16'h0010, 1'b0);
        write_slot(4'h5, 8'h09, 8'hFF, 16'h0010, 1'b0);
        image_wr.valid = 1'b0;
        step(2);
        check("pending", input_image.pending, 8'h05);
        check("last_seq", input_image.last_seq, 8'h45);
        check("next_seq", input_image.next_seq, 8'hC1);
        wait_pending(8'h00);
        check("next_seq", input_image.next_seq, 8'hC6);
        check("queue_status", input_image.queue_status, 8'h02);
        $display("test execution done");
        load_ticker(16'hFFE0);
        write_slot(4'h0, 8'h07, 8'hA5, 16'hFFF0, 1'b1);
        write_slot(4'h1, 8'h08, 8'h5A, 16'h0005, 1'b1);
        // already passed once the second entry runs: waits behind it
        write_slot(4'h2, 8'h49, 8'hC3, 16'h0003, 1'b0);
        image_wr.valid = 1'b0;
        step(2);
        check("last_seq", input_image.last_seq, 8'h49);
        check("queue_last", input_image.queue_status[7], 1'b1);
        wait_pending(8'h01);
        $display("test wrap done");
        for (int k = 0; k < 34; k++) begin
            write_slot(4'(k % 5), 8'(10 + k), 8'h00, 16'h8000, 1'b0);
        end
        image_wr.valid = 1'b0;
        step(3);
        check("pending", input_image.pending, 8'h20);
        check("overflow", input_image.queue_status[0], 1'b1);
        $display("test overflow done");
        do_reset(1'b1);
        check("channels_rst", channels, 4'h0);
        check("pending_rst", input_image.pending, 8'h00);
        read_param(1'b1, 16'h3101, 8'h00, 9'h03C);
        read_param(1'b0, 16'h0000, 8'h02, 9'h03C);
        write_slot(4'hE, 8'h03, 8'h00, 16'h8000, 1'b0);
        image_wr.valid = 1'b0;
        step(2);
        check("last_seq", input_image.last_seq, 8'h43);
        check("queue_left", 32'(exp_param.size() + exp_chan.size()), 32'h0);
        $display("test long variant done");
        report_and_stop();
    end
endmodule : timed_output_scheduler_test
